// ---- bench/sbsp_core_checker.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// burst port protocol checks
// ----------------------------------------
module sbsp_core_checker (
  input wire logic core_clk,                  // clock
  input wire logic reset,                     // sync reset
  input wire logic primary_select_low,        // select, low
  input wire logic depth_select_low,          // select, low
  input wire logic depth_select_high,         // select, high
  input wire logic output_drive_enable,       // output enable, low
  input wire logic processor_address_strobe,  // strobe, low
  input wire logic controller_address_strobe, // strobe, low
  input wire logic global_write_all,          // word write, low
  input wire logic snooze_request,            // snooze, high
  input wire logic shared_data_lines_oe_n,    // drive, low
  input wire logic power_down                 // power down flag
);
  // all three selects active
  wire sel = !primary_select_low && !depth_select_low && depth_select_high;
  // checks on the core clock
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  a_oe_async: assert property (output_drive_enable |-> shared_data_lines_oe_n)
    else $error("drivers on with enable high");
  a_snooze_off: assert property (snooze_request |-> shared_data_lines_oe_n)
    else $error("drivers on in snooze");
  a_snooze_pd: assert property (snooze_request [*3] |-> ##[0:2] power_down)
    else $error("snooze without power down");
  a_write_quiet: assert property (!controller_address_strobe && processor_address_strobe && sel
    && !global_write_all |-> ##3 shared_data_lines_oe_n) else $error("drivers on for write");
  a_read_drive: assert property (!processor_address_strobe && sel && !snooze_request ##1 global_write_all
    ##2 !output_drive_enable && !snooze_request |-> !shared_data_lines_oe_n) else $error("read not driven");
  a_desel_hiz: assert property (!controller_address_strobe && primary_select_low
    |-> ##3 shared_data_lines_oe_n) else $error("drivers on after deselect");
  a_desel_pd: assert property (!controller_address_strobe && processor_address_strobe && !sel
    |-> ##[1:3] power_down) else $error("deselect without power down");
  a_ps_ignored: assert property (!processor_address_strobe && controller_address_strobe
    && primary_select_low && power_down |=> power_down) else $error("strobe taken while unselected");
endmodule // sbsp_core_checker

bind sbsp_core sbsp_core_checker i_chk (.core_clk, .reset, .primary_select_low, .depth_select_low,
  .depth_select_high, .output_drive_enable, .processor_address_strobe, .controller_address_strobe,
  .global_write_all, .snooze_request, .shared_data_lines_oe_n, .power_down);

// ---- bench/sbsp_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// far side data line model
// ----------------------------------------
module sbsp_host_model (
  input  wire logic        core_clk,   // clock
  input  wire logic        host_drive, // far side drives
  input  wire logic [31:0] host_data,  // far side word
  input  wire logic [31:0] dev_data,   // device word
  input  wire logic        dev_oe_n,   // device drive, low
  output logic      [31:0] line_level  // resolved lines
);
  logic [31:0] last_q = 32'h0;
  // released lines flip every cycle
  always_comb begin
    if (host_drive) line_level = host_data;
    else if (!dev_oe_n) line_level = dev_data;
    else line_level = ~last_q;
  end
  // last seen level
  always_ff @(posedge core_clk) last_q <= line_level;
endmodule // sbsp_host_model

// ---- bench/sync_burst_sram_port_test.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// burst port test bench
// ----------------------------------------
module sync_burst_sram_port_test;
  logic        core_clk, reset, global_write_all, byte_write_gate, primary_select_low, depth_select_low;
  logic        depth_select_high, output_drive_enable, burst_step, processor_address_strobe;
  logic        controller_address_strobe, snooze_request, burst_order_select, host_drive;
  logic        shared_data_lines_oe_n, power_down;
  logic [3:0]  lanes;
  logic [14:0] address_in;
  logic [31:0] host_data, shared_data_lines_in, shared_data_lines_out;
  int          mismatches, checks_done;
  wire         byte_write_lane_0 = lanes[0];
  wire         byte_write_lane_1 = lanes[1];
  wire         byte_write_lane_2 = lanes[2];
  wire         byte_write_lane_3 = lanes[3];

  sbsp_core i_dut (.core_clk, .reset, .address_in, .byte_write_lane_0, .byte_write_lane_1,
    .byte_write_lane_2, .byte_write_lane_3, .global_write_all, .byte_write_gate, .primary_select_low,
    .depth_select_low, .depth_select_high, .output_drive_enable, .burst_step, .processor_address_strobe,
    .controller_address_strobe, .snooze_request, .burst_order_select, .shared_data_lines_in,
    .shared_data_lines_out, .shared_data_lines_oe_n, .power_down);
  sbsp_host_model i_host (.core_clk, .host_drive, .host_data, .dev_data(shared_data_lines_out),
    .dev_oe_n(shared_data_lines_oe_n), .line_level(shared_data_lines_in));

  // 200 MHz clock
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end

  task cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] w(input int i);
    return {4{8'hA0 + 8'(i)}};
  endfunction
  // one controller strobe write cycle
  task wr(input logic [14:0] a, input logic gw, input logic gate, input logic [3:0] ln, input logic [31:0] d);
    controller_address_strobe = 0;
    address_in = a;
    global_write_all = gw;
    byte_write_gate = gate;
    lanes = ln;
    host_data = d;
    host_drive = 1;
    cyc(1);
    controller_address_strobe = 1;
    global_write_all = 1;
    byte_write_gate = 1;
    lanes = 4'hF;
    host_drive = 0;
    cyc(1);
  endtask
  // processor strobe read, burst when n above one, selects dropped mid burst
  // valid selects held at every strobe edge
  task rd(input logic [14:0] a, input logic [31:0] e [4], input int n);
    processor_address_strobe = 0;
    address_in = a;
    for (int i = 0; i < n + 3; i++) begin
      if (i == 1) processor_address_strobe = 1;
      if (i == 1) burst_step = (n == 1);
      if (i == 2) depth_select_high = 0;
      if (i == 4) burst_step = 1;
      if (i >= 3) check(shared_data_lines_out, e[(i > 6) ? 3 : i - 3]);
      if (i == 3) check(32'(shared_data_lines_oe_n), 32'h0);
      cyc(1);
    end
    depth_select_high = 1;
  endtask

  task t_order;
    for (int i = 0; i < 4; i++) wr(15'h0100 + 15'(i), 0, 1, 4'hF, w(i));
    rd(15'h0101, '{w(1), w(0), w(3), w(2)}, 5);
    burst_order_select = 0;
    cyc(4);
    rd(15'h0102, '{w(2), w(3), w(0), w(1)}, 5);
    $display("order test done");
  endtask
  task t_bytes;
    for (int i = 0; i < 4; i++) begin
      wr(15'h0200 + 15'(i), 0, 1, 4'hF, 32'h0);
      wr(15'h0200 + 15'(i), 1, 0, ~(4'h1 << i), 32'hFFFF_FFFF);
      rd(15'h0200 + 15'(i), '{4{32'hFF << (8 * i)}}, 1);
    end
    wr(15'h0200, 1, 1, 4'h0, 32'h1234_5678);
    rd(15'h0200, '{4{32'h0000_00FF}}, 1);
    wr(15'h0200, 0, 0, 4'hE, 32'h1234_5678);
    rd(15'h0200, '{4{32'h1234_5678}}, 1);
    $display("byte test done");
  endtask
  task t_proc;
    processor_address_strobe = 0;
    global_write_all = 0;
    address_in = 15'h0200;
    host_data = 32'h0;
    host_drive = 1;
    cyc(1);
    processor_address_strobe = 1;
    global_write_all = 1;
    host_drive = 0;
    cyc(1);
    rd(15'h0200, '{4{32'h1234_5678}}, 1);
    processor_address_strobe = 0;
    address_in = 15'h0300;
    cyc(1);
    processor_address_strobe = 1;
    global_write_all = 0;
    host_data = 32'hC0DE_0300;
    host_drive = 1;
    cyc(1);
    global_write_all = 1;
    host_drive = 0;
    rd(15'h0300, '{4{32'hC0DE_0300}}, 1);
    controller_address_strobe = 0;
    primary_select_low = 1;
    cyc(1);
    controller_address_strobe = 1;
    processor_address_strobe = 0;
    cyc(2);
    processor_address_strobe = 1;
    cyc(2);
    check(32'(power_down), 32'h1);
    check(32'(shared_data_lines_oe_n), 32'h1);
    primary_select_low = 0;
    $display("strobe test done");
  endtask
  task t_power;
    rd(15'h0200, '{4{32'h1234_5678}}, 1);
    output_drive_enable = 1;
    #1 check(32'(shared_data_lines_oe_n), 32'h1);
    cyc(1);
    output_drive_enable = 0;
    #1 check(32'(shared_data_lines_oe_n), 32'h0);
    cyc(1);
    snooze_request = 1;
    #1 check(32'(shared_data_lines_oe_n), 32'h1);
    // strobes and write controls idle across snooze edges
    cyc(5);
    check(32'(power_down), 32'h1);
    snooze_request = 0;
    cyc(4);
    rd(15'h0300, '{4{32'hC0DE_0300}}, 1);
    $display("power test done");
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // idle controls high, reset for ten cycles, then the scenarios
  initial begin
    {reset, global_write_all, byte_write_gate, depth_select_high, burst_step, burst_order_select} = 6'h3F;
    {processor_address_strobe, controller_address_strobe, lanes} = 6'h3F;
    {primary_select_low, depth_select_low, output_drive_enable, snooze_request, host_drive} = 5'h0;
    address_in = 15'h0;
    host_data = 32'h0;
    cyc(10);
    reset = 0;
    t_order;
    t_bytes;
    t_proc;
    t_power;
    print_verdict;
  end
endmodule // sync_burst_sram_port_test

// ---- design/sbsp_array.sv ----
`timescale 1ns/1ps
`include "sbsp_map.svh"

// ----------------------------------------
// storage array with byte lanes
// ----------------------------------------
module sbsp_array #(
  parameter int ADDR_W = `SBSP_ADDR_W,
  parameter int DATA_W = `SBSP_DATA_W,
  parameter int BYTES  = `SBSP_BYTES
) (
  input  wire logic              core_clk, // clock
  input  wire logic [ADDR_W-1:0] addr,     // word address
  input  wire logic [BYTES-1:0]  wr_en,    // per byte write, high active
  input  wire logic [DATA_W-1:0] wr_data,  // write word
  output logic      [DATA_W-1:0] rd_data   // registered read word
);
  localparam int BW = DATA_W / BYTES;
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // byte lane writes, one process so the array has a single driver
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < BYTES; i++) begin
      if (wr_en[i]) begin
        mem[addr][i*BW +: BW] <= wr_data[i*BW +: BW];
      end
    end
  end

  // read register
  always_ff @(posedge core_clk) begin
    rd_data <= mem[addr];
  end
endmodule // sbsp_array

// ---- design/sbsp_core.sv ----
`timescale 1ns/1ps
`include "sbsp_map.svh"

// How it works
// RULE_01: address pins captured on rising edge
// RULE_02: each lane input gates one byte
// RULE_03: any lane low keeps drivers off
// RULE_04: global write stores whole word
// RULE_05: byte write needs gate plus lane
// RULE_06: all sync inputs latched each edge
// RULE_07: selects sampled only at address load
// RULE_08: output enable acts without clock
// RULE_09: step low advances, high waits
// RULE_10: far side holds step high first write
// RULE_11: processor strobe starts read, aborts burst
// RULE_12: processor strobe ignored when primary high
// RULE_13: controller strobe loads, else power-down
// RULE_14: snooze forces low power, keeps array
// RULE_15: far side restarts with strobe after snooze
// RULE_16: far side idles controls at snooze edge
// RULE_17: read data void in snooze rise
// RULE_18: order select low linear, high interleaved
// RULE_19: write needs control low, processor strobe high
// RULE_20: output enable ignored in write cycle
// RULE_21: far side gives valid selects at strobes
// RULE_22: interleaved order xors low bits
// RULE_23: linear order counts low bits mod four
// RULE_24: processor strobe read, write next edge
// RULE_25: read data through output register

module sbsp_core #(
  parameter int ADDR_W = `SBSP_ADDR_W,
  parameter int DATA_W = `SBSP_DATA_W,
  parameter int BYTES  = `SBSP_BYTES
) (
  input  wire logic              core_clk,                  // clock
  input  wire logic              reset,                     // sync reset, high
  input  wire logic [ADDR_W-1:0] address_in,                // address pins
  input  wire logic              byte_write_lane_0,         // lane 0 write, low
  input  wire logic              byte_write_lane_1,         // lane 1 write, low
  input  wire logic              byte_write_lane_2,         // lane 2 write, low
  input  wire logic              byte_write_lane_3,         // lane 3 write, low
  input  wire logic              global_write_all,          // whole word write, low
  input  wire logic              byte_write_gate,           // byte write gate, low
  input  wire logic              primary_select_low,        // primary select, low
  input  wire logic              depth_select_low,          // depth select, low
  input  wire logic              depth_select_high,         // depth select, high
  input  wire logic              output_drive_enable,       // async output enable, low
  input  wire logic              burst_step,                // burst advance, low
  input  wire logic              processor_address_strobe,  // processor strobe, low
  input  wire logic              controller_address_strobe, // controller strobe, low
  input  wire logic              snooze_request,            // power down, high
  input  wire logic              burst_order_select,        // low linear, high interleaved
  input  wire logic [DATA_W-1:0] shared_data_lines_in,      // data pins in
  output logic      [DATA_W-1:0] shared_data_lines_out,     // data pins out
  output logic                   shared_data_lines_oe_n,    // data drive, low drives
  output logic                   power_down                 // deselected or snoozing
);
  localparam int LW = `SBSP_LOW_W;

  // ----------------------------------------
  // input stage
  // ----------------------------------------
  logic [ADDR_W-1:0] addr_q;
  logic [BYTES-1:0]  lane_n_q;
  logic              gw_n_q, gate_n_q, ce1_n_q, ce2_n_q, ce2_q;
  logic              step_n_q, processor_address_strobe_n_q, controller_address_strobe_n_q, mode_q;
  logic [DATA_W-1:0] din_q;
  logic              zz_m_q, zz_q, zz_prev_q;

  // RULE_01 address register
  // RULE_06 latch all synchronous inputs
  always_ff @(posedge core_clk) begin
    addr_q   <= address_in;
    lane_n_q <= {byte_write_lane_3, byte_write_lane_2, byte_write_lane_1, byte_write_lane_0};
    gw_n_q   <= global_write_all;
    gate_n_q <= byte_write_gate;
    ce1_n_q  <= primary_select_low;
    ce2_n_q  <= depth_select_low;
    ce2_q    <= depth_select_high;
    step_n_q <= burst_step;
    processor_address_strobe_n_q <= processor_address_strobe;
    controller_address_strobe_n_q <= controller_address_strobe;
    din_q    <= shared_data_lines_in;
  end

  // RULE_18 mode pin synchroniser, static
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_q <= 1'b1;
    end else begin
      mode_q <= burst_order_select;
    end
  end

  // snooze synchroniser for internal state clearing
  always_ff @(posedge core_clk) begin
    if (reset) begin
      zz_m_q    <= 1'b0;
      zz_q      <= 1'b0;
      zz_prev_q <= 1'b0;
    end else begin
      zz_m_q    <= snooze_request;
      zz_q      <= zz_m_q;
      zz_prev_q <= zz_q;
    end
  end

  // ----------------------------------------
  // cycle decode
  // ----------------------------------------
  function automatic logic [BYTES-1:0] lane_write(input logic gw_n, input logic gate_n,
                                                  input logic [BYTES-1:0] lanes_n);
    // RULE_04 global write overrides
    // RULE_05 byte write gating
    // RULE_02 one lane per byte
    if (!gw_n) begin
      lane_write = '1;
    end else if (!gate_n) begin
      lane_write = ~lanes_n;
    end else begin
      lane_write = '0;
    end
  endfunction

  logic [BYTES-1:0] wr_lanes;
  logic             any_write, any_lane_low;
  logic             sel_ok, processor_address_strobe_load, controller_address_strobe_load, load, desel;
  assign wr_lanes     = lane_write(gw_n_q, gate_n_q, lane_n_q);
  assign any_lane_low = ~&lane_n_q;

  // RULE_19 write only with processor strobe high
  assign any_write = (|wr_lanes) && processor_address_strobe_n_q;

  // RULE_07 selects only read at load
  assign sel_ok    = !ce1_n_q && !ce2_n_q && ce2_q;
  // RULE_12 processor strobe needs primary select
  assign processor_address_strobe_load = !processor_address_strobe_n_q && !ce1_n_q;
  assign controller_address_strobe_load = !controller_address_strobe_n_q && !processor_address_strobe_load;
  assign load      = processor_address_strobe_load || controller_address_strobe_load;
  // RULE_13 any inactive select deselects
  assign desel     = load && !sel_ok;

  // ----------------------------------------
  // burst engine
  // ----------------------------------------
  sbsp_pkg::sbsp_access_e acc_q;
  logic [ADDR_W-1:0]      base_q;
  logic [LW-1:0]          cnt_q;
  logic [LW-1:0]          low_addr;
  logic [ADDR_W-1:0]      cur_addr;

  // RULE_22 interleaved xor of start bits
  // RULE_23 linear add modulo four
  assign low_addr = mode_q ? (base_q[LW-1:0] ^ cnt_q) : LW'(base_q[LW-1:0] + cnt_q);
  assign cur_addr = {base_q[ADDR_W-1:LW], low_addr};

  // RULE_11 processor strobe aborts burst and loads
  // RULE_13 controller strobe loads when selected
  // RULE_09 step advances, else wait
  // RULE_14 snooze drops burst state
  always_ff @(posedge core_clk) begin
    if (reset || zz_q) begin
      acc_q  <= sbsp_pkg::SBSP_IDLE;
      base_q <= '0;
      cnt_q  <= '0;
    end else if (load) begin
      cnt_q <= '0;
      if (desel) begin
        acc_q <= sbsp_pkg::SBSP_IDLE;
      end else begin
        base_q <= addr_q;
        // RULE_24 processor strobe always reads
        acc_q  <= (processor_address_strobe_load || !any_write) ? sbsp_pkg::SBSP_READ : sbsp_pkg::SBSP_WRITE;
      end
    end else if (acc_q != sbsp_pkg::SBSP_IDLE) begin
      if (!step_n_q) begin
        cnt_q <= LW'(cnt_q + `SBSP_STEP_ONE);
      end
      acc_q <= any_write ? sbsp_pkg::SBSP_WRITE : sbsp_pkg::SBSP_READ;
    end
  end

  // array address and write strobes for the current cycle
  logic [ADDR_W-1:0] arr_addr;
  logic [BYTES-1:0]  arr_wr;
  logic              active_next;
  assign arr_addr = (load && !desel) ? addr_q :
                    (!step_n_q && !load) ? {base_q[ADDR_W-1:LW],
                      (mode_q ? (base_q[LW-1:0] ^ LW'(cnt_q + `SBSP_STEP_ONE))
                              : LW'(base_q[LW-1:0] + cnt_q + `SBSP_STEP_ONE))} : cur_addr;

  // RULE_24 write in burst from the following edge
  // RULE_10 relies on step high before first write
  always_comb begin
    arr_wr = '0;
    if (!zz_q && !reset && any_write) begin
      if (controller_address_strobe_load && sel_ok) begin
        arr_wr = wr_lanes;
      end else if (!load && acc_q != sbsp_pkg::SBSP_IDLE) begin
        arr_wr = wr_lanes;
      end
    end
  end

  assign active_next = (load && !desel) || (!load && acc_q != sbsp_pkg::SBSP_IDLE);

  // ----------------------------------------
  // array and output register
  // ----------------------------------------
  logic [DATA_W-1:0] rd_word;

  // RULE_25 registered read data
  sbsp_array #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W),
    .BYTES  (BYTES)
  ) u_array (
    .core_clk (core_clk),
    .addr     (arr_addr),
    .wr_en    (arr_wr),
    .wr_data  (din_q),
    .rd_data  (rd_word)
  );

  // read-valid registers on the same edge as the array read
  // drive_q lines up with the output register, one edge after the array read
  logic rd_valid_q, wr_cyc_q, drive_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_valid_q <= 1'b0;
      wr_cyc_q   <= 1'b0;
      drive_q    <= 1'b0;
    end else begin
      drive_q    <= rd_valid_q;
      // RULE_17 no valid data around snooze edge
      rd_valid_q <= active_next && !(|arr_wr) && !zz_q && !zz_prev_q;
      // RULE_03 any lane low blanks drivers
      // RULE_20 write cycle overrides output enable
      wr_cyc_q   <= any_lane_low || (|arr_wr) || !gw_n_q;
    end
  end

  // data output register
  always_ff @(posedge core_clk) begin
    if (reset) begin
      shared_data_lines_out <= '0;
    end else begin
      shared_data_lines_out <= rd_word;
    end
  end

  // RULE_08 asynchronous output enable
  // RULE_14 snooze forces drivers off
  // RULE_03 lane sampled low blanks drivers at once
  assign shared_data_lines_oe_n = output_drive_enable || snooze_request || !drive_q || wr_cyc_q || any_lane_low;

  // deselect or snooze status
  always_ff @(posedge core_clk) begin
    if (reset) begin
      power_down <= 1'b1;
    end else begin
      power_down <= zz_q || !active_next;
    end
  end
endmodule // sbsp_core

// ---- design/sbsp_map.svh ----
`ifndef SBSP_MAP_SVH
`define SBSP_MAP_SVH

// array geometry
`define SBSP_ADDR_W      15
`define SBSP_DATA_W      32
`define SBSP_BYTES       4
`define SBSP_BYTE_W      8
`define SBSP_LOW_W       2

// burst counter step, both orders
`define SBSP_STEP_ONE    2'h1

`endif

// ---- design/sbsp_pkg.sv ----
package sbsp_pkg;
  // current access kind held in the burst engine
  typedef enum logic [1:0] {
    SBSP_IDLE,
    SBSP_READ,
    SBSP_WRITE
  } sbsp_access_e;
endpackage
